/* core/rtc_irq_latch.sv */
// Clock counters, interrupt status, alarm compare and time-save control
// Contract
// - Any access to periodic flags clears them
// - Status D0 mirrors any active interrupt output
// - Alarm match sets status; enable gates pin
// - Periodic enables mask only the summary bit
// - Power-fail interrupt needs enable and failure
// - No enables and no pending summary flag means no interrupt output
// - Write one clears status D2 or D3
// - Alarm when all enabled compare bytes match
// - Periodic events fire at counter rollover
// - Any enabled periodic event sets summary flag
// - Writing one clears summary flag and interrupt
// - Pending summary flag survives disabling enables
// - Power-fail flag follows input, not clearable
// - Chip select delays lockout during access
// - Save enable tracks; falling edge freezes time
// - Time save writes only used bits
// - Save storage is plain storage when disabled
// - Stop halts counting, carries and prescaler
// - Prescaler divides to 32 kHz then 100 Hz
// - Select bit chooses register block
`timescale 1ns/1ns
module rtc_irq_latch #(
    parameter int N = rtc_pkg::NUM_BYTES,
    parameter int DIV_A = rtc_pkg::DIV_TO_MID,
    parameter int DIV_B = rtc_pkg::DIV_TO_TICK
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic chipSelN,
    input wire logic readN,
    input wire logic writeN,
    input wire logic [4:0] addr,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    input wire logic power_loss_in_n,
    output logic irq_out_n,
    output logic multi_purpose_out
);
    rtc_save_if saveBus ();

    logic lockout;
    logic rdActive;
    logic wrActive;
    logic perRdPrev;
    logic wrPrev;
    logic [4:0] wrAddr;
    logic [7:0] wrData;
    logic commit;
    logic perRdNow;
    logic regSel;
    logic selBit;
    logic [7:0] rtMode;
    logic [7:0] saveCtrl;
    logic [7:0] outCfg;
    logic [7:0] perEnable;
    logic [7:0] alarmPfEn;
    logic [7:0] perFlags;
    logic periodicFlag;
    logic alarmFlag;
    logic pfFlag;
    logic irqActive;
    logic matchPrev;
    logic alarmMatch;
    logic run;
    logic tick100;
    logic [7:0] cnt [N];
    logic [7:0] cmpReg [N];
    logic [N:0] carry;
    logic [N-1:0] byteEq;
    logic [5:0] perTicks;
    logic perSet;
    logic alarmIrq;
    logic pfIrq;
    logic next_irqActive;
    logic [7:0] rdMux;
    logic [4:0] cntIdx;
    logic [4:0] cmpIdx;
    logic [4:0] saveIdx;
    logic wrIsCnt;
    logic wrIsCmp;
    logic wrIsSave;
    logic [47:0] liveTime;

    // BCD increment of one byte with wrap
    function automatic logic [7:0] bcdInc(input logic [7:0] v, input logic [7:0] mx,
                                          input logic [7:0] mn);
        logic [7:0] r;
        r = 8'h00;
        if (v == mx) begin
            r = mn;
        end else if (v[3:0] == 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    // Strobes qualified by chip select and the lockout
    assign rdActive = !lockout && !chipSelN && !readN;
    assign wrActive = !lockout && !chipSelN && !writeN;
    assign commit = wrPrev && !wrActive;
    assign perRdNow = rdActive && addr == rtc_pkg::OFS_PER_FLAGS && !regSel;
    assign run = rtMode[rtc_pkg::RT_START];
    assign regSel = selBit;

    // Lockout only starts while no access is under way
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            lockout <= 1'b0;
        end else begin
            lockout <= !power_loss_in_n && (lockout || chipSelN);
        end
    end

    // Track strobes and hold the last written address and data
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            perRdPrev <= 1'b0;
            wrPrev <= 1'b0;
            wrAddr <= 5'h00;
            wrData <= 8'h00;
        end else begin
            perRdPrev <= perRdNow;
            wrPrev <= wrActive;
            if (wrActive) begin
                wrAddr <= addr;
                wrData <= dataIn;
            end
        end
    end

    // Address helpers for the counter, compare and save windows
    assign cntIdx = wrAddr - rtc_pkg::OFS_COUNTER0;
    assign cmpIdx = wrAddr - rtc_pkg::OFS_COMPARE0;
    assign saveIdx = wrAddr - rtc_pkg::OFS_SAVE0;
    assign wrIsCnt = commit && wrAddr >= rtc_pkg::OFS_COUNTER0 && cntIdx < 5'(N);
    assign wrIsCmp = commit && wrAddr >= rtc_pkg::OFS_COMPARE0 && cmpIdx < 5'(N);
    assign wrIsSave = commit && wrAddr >= rtc_pkg::OFS_SAVE0 && saveIdx < 5'(N);

    // Control registers; the select bit switches the block
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            selBit <= 1'b0;
            rtMode <= rtc_pkg::RST_CTRL;
            saveCtrl <= rtc_pkg::RST_CTRL;
            outCfg <= rtc_pkg::RST_CTRL;
            perEnable <= rtc_pkg::RST_CTRL;
            alarmPfEn <= rtc_pkg::RST_CTRL;
        end else if (commit) begin
            if (wrAddr == rtc_pkg::OFS_MAIN_STATUS) begin
                selBit <= wrData[rtc_pkg::MS_REG_SEL];
            end else if (!regSel && wrAddr == rtc_pkg::OFS_RT_MODE) begin
                rtMode <= wrData;
            end else if (regSel && wrAddr == rtc_pkg::OFS_SAVE_CTRL) begin
                saveCtrl <= wrData;
            end else if (regSel && wrAddr == rtc_pkg::OFS_OUTPUT_CFG) begin
                outCfg <= wrData;
            end else if (regSel && wrAddr == rtc_pkg::OFS_PER_ENABLE) begin
                perEnable <= wrData;
            end else if (regSel && wrAddr == rtc_pkg::OFS_ALARM_PF_EN) begin
                alarmPfEn <= wrData;
            end
        end
    end

    // Counter chain; carries only flow while running
    assign carry[0] = tick100 && run;
    for (genvar i = 0; i < N; i++) begin : g_cnt
        assign carry[i+1] = carry[i] && cnt[i] == rtc_pkg::CNT_MAX[8*i +: 8];
        assign byteEq[i] = !alarmPfEn[i] || cnt[i] == cmpReg[i];
        assign liveTime[8*i +: 8] = cnt[i];
        always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
                cnt[i] <= rtc_pkg::CNT_MIN[8*i +: 8];
                cmpReg[i] <= 8'h00;
            end else begin
                if (wrIsCnt && cntIdx == 5'(i)) begin
                    cnt[i] <= wrData;
                end else if (carry[i]) begin
                    cnt[i] <= bcdInc(cnt[i], rtc_pkg::CNT_MAX[8*i +: 8],
                                     rtc_pkg::CNT_MIN[8*i +: 8]);
                end
                if (wrIsCmp && cmpIdx == 5'(i)) begin
                    cmpReg[i] <= wrData;
                end
            end
        end
    end

    rtc_prescaler #(.DIV_A(DIV_A), .DIV_B(DIV_B)) u_prescaler (
        .clock(clock),
        .sys_rst(sys_rst),
        .run(run),
        .tick100(tick100)
    );

    // Periodic ticks at 10 ms, 100 ms, 1 s, 10 s, 1 min and 1 h
    assign perTicks = {carry[3], carry[2], carry[1] && cnt[1][3:0] == 4'h9,
                       carry[1], carry[0] && cnt[0][3:0] == 4'h9, carry[0]};
    assign perSet = |(perTicks & perEnable[5:0]);

    // Periodic flags clear when a flag read ends, so the host sees them first;
    // a tick in the clearing cycle still lands
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            perFlags <= 8'h00;
        end else if ((perRdPrev && !perRdNow)
                     || (commit && wrAddr == rtc_pkg::OFS_PER_FLAGS && !regSel)) begin
            perFlags <= {2'b00, perTicks};
        end else begin
            perFlags <= perFlags | {2'b00, perTicks};
        end
    end

    // Alarm match edge
    assign alarmMatch = (|alarmPfEn[5:0]) && (&byteEq); // No byte enabled, no alarm
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            matchPrev <= 1'b0;
        end else begin
            matchPrev <= alarmMatch;
        end
    end

    // Main status flags; set wins over a write-one clear
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            periodicFlag <= 1'b0;
            alarmFlag <= 1'b0;
        end else begin
            if (perSet) begin
                periodicFlag <= 1'b1;
            end else if (commit && wrAddr == rtc_pkg::OFS_MAIN_STATUS
                         && wrData[rtc_pkg::MS_PERIODIC]) begin
                periodicFlag <= 1'b0;
            end
            if (alarmMatch && !matchPrev) begin
                alarmFlag <= 1'b1;
            end else if (commit && wrAddr == rtc_pkg::OFS_MAIN_STATUS
                         && wrData[rtc_pkg::MS_ALARM]) begin
                alarmFlag <= 1'b0;
            end
        end
    end

    // Power-fail flag mirrors the input; host writes have no effect
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pfFlag <= 1'b0;
        end else begin
            pfFlag <= !power_loss_in_n;
        end
    end

    // Interrupt routing; alarm and power fail need their enables, the periodic flag is not gated
    assign alarmIrq = alarmFlag && alarmPfEn[rtc_pkg::AP_ALARM_EN];
    assign pfIrq = pfFlag && alarmPfEn[rtc_pkg::AP_PF_EN];
    assign next_irqActive = alarmIrq || periodicFlag || pfIrq;

    // Pins and the D0 summary come from the same decision
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irqActive <= 1'b0;
            irq_out_n <= 1'b1;
            multi_purpose_out <= 1'b0;
        end else begin
            irqActive <= next_irqActive;
            irq_out_n <= !(alarmIrq || periodicFlag
                           || (pfIrq && !outCfg[rtc_pkg::OC_PF_ON_MPO]));
            multi_purpose_out <= pfIrq && outCfg[rtc_pkg::OC_PF_ON_MPO];
        end
    end

    // Time-save storage hookup
    assign saveBus.track = saveCtrl[rtc_pkg::SAVE_EN];
    assign saveBus.liveTime = liveTime;
    assign saveBus.hostWe = wrIsSave && !saveCtrl[rtc_pkg::SAVE_EN];
    assign saveBus.hostAddr = saveIdx[2:0];
    assign saveBus.hostData = wrData;
    assign saveBus.rdAddr = 3'(addr - rtc_pkg::OFS_SAVE0);

    rtc_save_ram u_save (
        .clock(clock),
        .sys_rst(sys_rst),
        .bus(saveBus)
    );

    // Read multiplexer
    always_comb begin
        rdMux = 8'h00;
        if (addr == rtc_pkg::OFS_MAIN_STATUS) begin
            rdMux = {1'b0, regSel, 2'b00, alarmFlag, periodicFlag, pfFlag, irqActive};
        end else if (addr >= rtc_pkg::OFS_SAVE0 && addr < rtc_pkg::OFS_SAVE0 + 5'(N)) begin
            rdMux = saveBus.rdData;
        end else if (addr >= rtc_pkg::OFS_COMPARE0 && addr < rtc_pkg::OFS_SAVE0) begin
            rdMux = cmpReg[3'(addr - rtc_pkg::OFS_COMPARE0)];
        end else if (addr >= rtc_pkg::OFS_COUNTER0 && addr < rtc_pkg::OFS_COMPARE0) begin
            rdMux = cnt[3'(addr - rtc_pkg::OFS_COUNTER0)];
        end else if (!regSel) begin
            case (addr)
                rtc_pkg::OFS_RT_MODE: rdMux = rtMode;
                rtc_pkg::OFS_PER_FLAGS: rdMux = perFlags;
                default: rdMux = 8'h00;
            endcase
        end else begin
            case (addr)
                rtc_pkg::OFS_SAVE_CTRL: rdMux = saveCtrl;
                rtc_pkg::OFS_OUTPUT_CFG: rdMux = outCfg;
                rtc_pkg::OFS_PER_ENABLE: rdMux = perEnable;
                rtc_pkg::OFS_ALARM_PF_EN: rdMux = alarmPfEn;
                default: rdMux = 8'h00;
            endcase
        end
    end

    // Data bus drive follows the read strobe
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dataOut <= 8'h00;
            dataOe <= 1'b0;
        end else begin
            dataOut <= rdMux;
            dataOe <= rdActive;
        end
    end

    a_d0_tracks: assert property (@(posedge clock) disable iff (sys_rst)
        irqActive == (!irq_out_n || multi_purpose_out))
        else $error("summary bit disagrees with pins");
    a_no_enables: assert property (@(posedge clock) disable iff (sys_rst)
        (perEnable == 8'h00 && alarmPfEn[7:6] == 2'b00 && !periodicFlag)
        |=> irq_out_n && !multi_purpose_out) else $error("irq with no enable");
    a_alarm_sets: assert property (@(posedge clock) disable iff (sys_rst)
        alarmMatch && !matchPrev |=> alarmFlag) else $error("alarm missed");
    a_per_clear: assert property (@(posedge clock) disable iff (sys_rst)
        commit && wrAddr == rtc_pkg::OFS_PER_FLAGS && !regSel && perTicks == 6'h00
        |=> perFlags == 8'h00) else $error("periodic flags kept after write");
    a_pf_follow: assert property (@(posedge clock) disable iff (sys_rst)
        ##1 pfFlag == !$past(power_loss_in_n)) else $error("pf flag stale");
    a_pend_hold: assert property (@(posedge clock) disable iff (sys_rst)
        periodicFlag && !(commit && wrAddr == 5'h00 && wrData[2]) |=> periodicFlag)
        else $error("periodic flag dropped");
    a_stop_hold: assert property (@(posedge clock) disable iff (sys_rst)
        !run && !wrIsCnt |=> cnt[0] == $past(cnt[0]))
        else $error("counted while stopped");
    a_lock_access: assert property (@(posedge clock) disable iff (sys_rst)
        !lockout && !chipSelN |=> !lockout) else $error("lockout cut access");
    c_alarm: cover property (@(posedge clock) alarmFlag && !irq_out_n);
    c_periodic: cover property (@(posedge clock) perSet);
    c_freeze: cover property (@(posedge clock) $fell(saveBus.track));
endmodule // rtc_irq_latch

/* core/rtc_prescaler.sv */
// Two-stage divider from the system clock to the 100 Hz counting tick
`timescale 1ns/1ns
module rtc_prescaler #(
    parameter int DIV_A = rtc_pkg::DIV_TO_MID,
    parameter int DIV_B = rtc_pkg::DIV_TO_TICK
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic run,
    output logic tick100
);
    logic [11:0] cntA;
    logic [9:0] cntB;

    // Divide down; a stopped clock holds both stages at zero
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cntA <= 12'h000;
            cntB <= 10'h000;
            tick100 <= 1'b0;
        end else if (!run) begin
            cntA <= 12'h000;
            cntB <= 10'h000;
            tick100 <= 1'b0;
        end else begin
            tick100 <= 1'b0;
            if (cntA == 12'(DIV_A - 1)) begin
                cntA <= 12'h000;
                if (cntB == 10'(DIV_B - 1)) begin
                    cntB <= 10'h000;
                    tick100 <= 1'b1;
                end else begin
                    cntB <= cntB + 10'h001;
                end
            end else begin
                cntA <= cntA + 12'h001;
            end
        end
    end

    a_stop_quiet: assert property (@(posedge clock) disable iff (sys_rst)
        !run |=> !tick100) else $error("tick while stopped");
    a_tick_phase: assert property (@(posedge clock) disable iff (sys_rst)
        tick100 |-> cntA == 12'h000 && cntB == 10'h000)
        else $error("tick off divider phase");
endmodule // rtc_prescaler

/* core/rtc_save_ram.sv */
// Time-save storage: tracks the counters or serves as plain host storage
`timescale 1ns/1ns
module rtc_save_ram #(
    parameter int N = rtc_pkg::NUM_BYTES
) (
    input wire logic clock,
    input wire logic sys_rst,
    rtc_save_if.mem bus
);
    logic [7:0] mem [N];

    // One storage byte per counter
    for (genvar i = 0; i < N; i++) begin : g_byte
        always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
                mem[i] <= 8'h00;
            end else if (bus.track) begin
                mem[i] <= (mem[i] & ~rtc_pkg::SAVE_MASK[8*i +: 8])
                    | (bus.liveTime[8*i +: 8] & rtc_pkg::SAVE_MASK[8*i +: 8]);
            end else if (bus.hostWe && bus.hostAddr == 3'(i)) begin
                mem[i] <= bus.hostData;
            end
        end
    end

    // Registered read port
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bus.rdData <= 8'h00;
        end else if (int'(bus.rdAddr) < N) begin
            bus.rdData <= mem[bus.rdAddr];
        end else begin
            bus.rdData <= 8'h00;
        end
    end

    a_track_copy: assert property (@(posedge clock) disable iff (sys_rst)
        bus.track |=> ((mem[0] ^ $past(bus.liveTime[7:0]))
        & rtc_pkg::SAVE_MASK[7:0]) == 8'h00)
        else $error("save byte did not follow counter");
    a_unused_kept: assert property (@(posedge clock) disable iff (sys_rst)
        bus.track |=> (mem[1] & ~rtc_pkg::SAVE_MASK[15:8])
        == ($past(mem[1]) & ~rtc_pkg::SAVE_MASK[15:8]))
        else $error("unused save bit changed");
endmodule // rtc_save_ram

/* inc/rtc_pkg.sv */
// Shared constants for the clock interrupt and time-save block
package rtc_pkg;
    // Clock and prescaler figures
    localparam int CLK_HZ = 50_000_000;
    localparam int MID_HZ = 32_000;
    localparam int TICK_HZ = 100;
    localparam int DIV_TO_MID = CLK_HZ / MID_HZ;
    localparam int DIV_TO_TICK = MID_HZ / TICK_HZ;
    // Register offsets
    localparam logic [4:0] OFS_MAIN_STATUS = 5'h00;
    localparam logic [4:0] OFS_RT_MODE = 5'h01;
    localparam logic [4:0] OFS_SAVE_CTRL = 5'h01;
    localparam logic [4:0] OFS_OUTPUT_CFG = 5'h02;
    localparam logic [4:0] OFS_PER_FLAGS = 5'h03;
    localparam logic [4:0] OFS_PER_ENABLE = 5'h03;
    localparam logic [4:0] OFS_ALARM_PF_EN = 5'h04;
    localparam logic [4:0] OFS_COUNTER0 = 5'h05;
    localparam logic [4:0] OFS_COMPARE0 = 5'h0b;
    localparam logic [4:0] OFS_SAVE0 = 5'h11;
    localparam int NUM_BYTES = 6;
    // Main status bit positions
    localparam int MS_IRQ = 0;
    localparam int MS_POWER_LOSS_IN_N = 1;
    localparam int MS_PERIODIC = 2;
    localparam int MS_ALARM = 3;
    localparam int MS_REG_SEL = 6;
    // Control bit positions
    localparam int RT_START = 3;
    localparam int SAVE_EN = 7;
    localparam int OC_PF_ON_MPO = 0;
    localparam int AP_PF_EN = 6;
    localparam int AP_ALARM_EN = 7;
    // Reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    // Counter limits in BCD, least significant byte first
    localparam logic [47:0] CNT_MAX = 48'h12_31_23_59_59_99;
    localparam logic [47:0] CNT_MIN = 48'h01_01_00_00_00_00;
    // Bits really used by each counter byte
    localparam logic [47:0] SAVE_MASK = 48'h1f_3f_3f_7f_7f_ff;
endpackage

/* inc/rtc_save_if.sv */
// Port bundle between the control logic and the time-save storage
`timescale 1ns/1ns
interface rtc_save_if;
    logic hostWe;
    logic [2:0] hostAddr;
    logic [7:0] hostData;
    logic track;
    logic [47:0] liveTime;
    logic [2:0] rdAddr;
    logic [7:0] rdData;
    modport mem (input hostWe, hostAddr, hostData, track, liveTime, rdAddr, output rdData);
    modport user (output hostWe, hostAddr, hostData, track, liveTime, rdAddr, input rdData);
endinterface

/* verification/rtc_host_model.sv */
// Host processor model driving the byte-wide strobe bus
`timescale 1ns/1ns
module rtc_host_model (
    input wire logic clock,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    output logic chipSelN,
    output logic readN,
    output logic writeN,
    output logic [4:0] addr,
    output logic [7:0] dataIn,
    output logic power_loss_in_n
);
    logic [7:0] hostData = 8'h00;
    logic [7:0] idleData = 8'h5a;
    logic hostDrive = 1'b0;
    // Idle bus levels
    initial begin
        chipSelN = 1'b1;
        readN = 1'b1;
        writeN = 1'b1;
        addr = 5'h00;
        power_loss_in_n = 1'b1;
    end
    // Undriven bus keeps changing so a stale value never looks valid
    always @(negedge clock) idleData <= ~idleData;
    assign dataIn = dataOe ? dataOut : (hostDrive ? hostData : idleData);
    // Write cycle: strobe low two cycles, then idle
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge clock);
        addr = a;
        hostData = d;
        hostDrive = 1'b1;
        chipSelN = 1'b0;
        writeN = 1'b0;
        repeat (2) @(negedge clock);
        chipSelN = 1'b1;
        writeN = 1'b1;
        hostDrive = 1'b0;
        repeat (2) @(negedge clock);
    endtask
    // Read cycle; drop pulls the supply low while select is held
    task automatic rd(input logic [4:0] a, input logic drop, output logic [7:0] d);
        @(negedge clock);
        addr = a;
        chipSelN = 1'b0;
        readN = 1'b0;
        @(negedge clock);
        if (drop) power_loss_in_n = 1'b0;
        repeat (4) @(negedge clock);
        d = dataOut;
        chipSelN = 1'b1;
        readN = 1'b1;
        repeat (2) @(negedge clock);
    endtask
    // Supply detector level
    task automatic pw(input logic v);
        @(negedge clock);
        power_loss_in_n = v;
        repeat (3) @(negedge clock);
    endtask
endmodule // rtc_host_model

/* verification/tb_rtc_irq_latch.sv */
// Self-checking bench for the interrupt and time-save block
`timescale 1ns/1ns
module tb_rtc_irq_latch;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic chipSelN, readN, writeN, dataOe, power_loss_in_n, irq_out_n, multi_purpose_out;
    logic [4:0] addr;
    logic [7:0] dataIn, dataOut, rdVal;
    int miscompares = 0;
    int tests_run = 0;
    // Short divider so periodic ticks come every four clocks
    rtc_irq_latch #(.N(rtc_pkg::NUM_BYTES), .DIV_A(2), .DIV_B(2)) u_rtc_irq_latch (
        .clock(clock), .sys_rst(sys_rst),
        .chipSelN(chipSelN), .readN(readN), .writeN(writeN), .addr(addr), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe), .power_loss_in_n(power_loss_in_n),
        .irq_out_n(irq_out_n), .multi_purpose_out(multi_purpose_out));
    rtc_host_model u_rtc_host_model (.clock(clock), .dataOut(dataOut), .dataOe(dataOe),
        .chipSelN(chipSelN), .readN(readN), .writeN(writeN), .addr(addr), .dataIn(dataIn),
        .power_loss_in_n(power_loss_in_n));
    // 50 MHz clock
    initial begin
        forever #10 clock = ~clock;
    end
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
        u_rtc_host_model.rd(a, 1'b0, rdVal);
        check(rdVal, exp);
    endtask
    task automatic w(input logic [4:0] a, input logic [7:0] d);
        u_rtc_host_model.wr(a, d);
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Quiet outputs after reset, then switch to block 1
    task automatic test_reset();
        check({7'h00, irq_out_n}, 8'h01);
        check({7'h00, multi_purpose_out}, 8'h00);
        rchk(5'h00, 8'h00);
        w(5'h00, 8'h40);
        rchk(5'h00, 8'h40);
        rchk(5'h03, 8'h00);
        rchk(5'h04, 8'h00);
    endtask
    // Alarm status, pin gating and write-one clearing
    task automatic test_alarm();
        w(5'h0c, 8'h45);
        w(5'h04, 8'h02);
        w(5'h06, 8'h45);
        rchk(5'h00, 8'h48);
        check({7'h00, irq_out_n}, 8'h01);
        w(5'h00, 8'h40);
        rchk(5'h00, 8'h48);
        w(5'h00, 8'h48);
        rchk(5'h00, 8'h40);
        // Two bytes enabled: a seconds match alone must not fire
        w(5'h0b, 8'h11);
        w(5'h04, 8'h83);
        w(5'h06, 8'h44);
        w(5'h06, 8'h45);
        rchk(5'h00, 8'h40);
        w(5'h05, 8'h11);
        @(negedge clock);
        check({7'h00, irq_out_n}, 8'h00);
        rchk(5'h00, 8'h49);
        w(5'h00, 8'h48);
        check({7'h00, irq_out_n}, 8'h01);
        rchk(5'h00, 8'h40);
        w(5'h04, 8'h00);
    endtask
    // Power-fail flag, routed output and lockout
    task automatic test_power();
        w(5'h02, 8'h01);
        w(5'h04, 8'h40);
        w(5'h00, 8'h00);
        rchk(5'h02, 8'h00);
        w(5'h00, 8'h40);
        rchk(5'h02, 8'h01);
        u_rtc_host_model.rd(5'h00, 1'b1, rdVal);
        check(rdVal, 8'h43);
        check({7'h00, dataOe}, 8'h00);
        check({7'h00, multi_purpose_out}, 8'h01);
        w(5'h04, 8'h00);
        u_rtc_host_model.pw(1'b1);
        check({7'h00, multi_purpose_out}, 8'h00);
        rchk(5'h04, 8'h40);
        rchk(5'h00, 8'h40);
        // Enable cleared: failure stays off the pins
        w(5'h04, 8'h00);
        u_rtc_host_model.pw(1'b0);
        check({7'h00, multi_purpose_out}, 8'h00);
        check({7'h00, irq_out_n}, 8'h01);
        u_rtc_host_model.pw(1'b1);
    endtask
    // Time-save storage and latch with the clock stopped
    task automatic test_save();
        w(5'h01, 8'h00);
        w(5'h11, 8'ha5);
        w(5'h12, 8'hff);
        rchk(5'h11, 8'ha5);
        w(5'h01, 8'h80);
        w(5'h05, 8'h22);
        w(5'h01, 8'h00);
        rchk(5'h11, 8'h22);
        rchk(5'h12, 8'hc5);
        rchk(5'h05, 8'h22);
    endtask
    // Periodic flags, summary bit, validated read and an on-the-fly write
    task automatic test_periodic();
        w(5'h03, 8'h01);
        w(5'h00, 8'h00);
        w(5'h01, 8'h08);
        wait (irq_out_n == 1'b0);
        repeat (800) @(negedge clock);
        w(5'h08, 8'h07);
        w(5'h01, 8'h00);
        rchk(5'h00, 8'h05);
        rchk(5'h03, 8'h07);
        u_rtc_host_model.rd(5'h05, 1'b0, rdVal);
        rchk(5'h03, 8'h00);
        w(5'h03, 8'hff);
        rchk(5'h03, 8'h00);
        w(5'h00, 8'h40);
        w(5'h03, 8'h00);
        rchk(5'h00, 8'h45);
        check({7'h00, irq_out_n}, 8'h00);
        w(5'h00, 8'h44);
        check({7'h00, irq_out_n}, 8'h01);
        rchk(5'h00, 8'h40);
        rchk(5'h08, 8'h07);
    endtask
    // Main sequence
    initial begin
        repeat (20) @(negedge clock);
        sys_rst = 1'b0;
        @(negedge clock);
        test_reset();
        test_alarm();
        test_power();
        test_save();
        test_periodic();
        finish_test();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        $display("wrong value at %0t: run did not finish", $time);
        finish_test();
    end
endmodule // tb_rtc_irq_latch
